// [design/isc_pkg.sv]
package isc_pkg;

  // register map of the converter, link address space
  localparam logic [7:0]  ADDR_CONTROL_WORD  = 8'h1A;
  localparam logic [7:0]  ADDR_SCAN_CONFIG   = 8'h1B;

  // device_control_word field positions
  localparam int          CW_CHAN_HI         = 15;
  localparam int          CW_CHAN_LO         = 14;
  localparam int          CW_SLEEP           = 13;
  localparam int          CW_OVERRIDE        = 12;
  localparam int          CW_ACT_STYLE       = 11;
  localparam int          CW_AMP_OFF         = 10;
  localparam int          CW_REF_SRC         = 9;
  localparam int          CW_RSVD8           = 8;
  localparam int          CW_INT_MASK        = 7;
  localparam int          CW_BOOST           = 6;
  localparam int          CW_RSVD_HI         = 5;
  localparam logic [5:0]  CW_RSVD_LOW_VALUE  = 6'h01;

  // channel_scan_config field positions
  localparam int          SC_SCAN_ON         = 15;
  localparam int          SC_ORDER_HI        = 14;
  localparam int          SC_ORDER_LO        = 13;
  localparam int          SC_DEGLITCH_HI     = 2;

  // reset values
  localparam logic [15:0] CONTROL_WORD_RESET = 16'h2801;
  localparam logic [15:0] SCAN_CONFIG_RESET  = 16'h020F;

  // scan order codes
  localparam logic [1:0]  ORDER_CH01         = 2'h0;
  localparam logic [1:0]  ORDER_CH012        = 2'h1;
  localparam logic [1:0]  ORDER_CH0123       = 2'h2;

  // timing: internal oscillator period and phase lengths in reference ticks
  localparam int          INT_OSC_NS         = 80;
  localparam int          MCLK_NS            = 20;
  localparam int          INT_OSC_CYCLES     = (INT_OSC_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [7:0]  ACT_TICKS          = 8'h08;
  localparam logic [7:0]  CONV_TICKS         = 8'h20;
  localparam logic [4:0]  FULL_DRIVE         = 5'h1F;

  // host side register map (avalon byte addresses)
  localparam logic [3:0]  HOST_CMD_ADDR      = 4'h0;
  localparam logic [3:0]  HOST_CMD_DATA      = 4'h4;
  localparam logic [3:0]  HOST_CTRL          = 4'h8;
  localparam logic [3:0]  HOST_STATUS        = 4'hC;
  localparam int          HOST_GO_WRITE      = 0;
  localparam int          HOST_GO_READ       = 1;

  typedef enum logic [2:0] {
    ST_SLEEP    = 3'b001,
    ST_ACTIVATE = 3'b010,
    ST_CONVERT  = 3'b100
  } isc_state_t;

  // pick one channel's 5-bit field out of a packed four-channel vector
  function automatic logic [4:0] isc_pick5(input logic [19:0] vec, input logic [1:0] ch);
    logic [4:0] r;
    r = vec[ch*5 +: 5];
    return r;
  endfunction

  // highest channel of a scan order
  function automatic logic [1:0] isc_last_channel(input logic [1:0] order);
    logic [1:0] r;
    case (order)
      ORDER_CH012:  r = 2'h2;
      ORDER_CH0123: r = 2'h3;
      default:      r = 2'h1;
    endcase
    return r;
  endfunction

endpackage

// [design/isc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// register link between host controller and converter
interface isc_link_if;
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        int_n;

  modport device (input req, input we, input addr, input wdata,
                  output rdata, output ack, output int_n);
  modport host   (output req, output we, output addr, output wdata,
                  input rdata, input ack, input int_n);
endinterface
`default_nettype wire

// [design/isc_scan_seq.sv]
`timescale 1ns/1ps
`default_nettype none
// steps through the channel sequence, or holds the single channel
module isc_scan_seq
  import isc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_restart,
  input  wire logic       i_advance,
  input  wire logic       i_scan_on,
  input  wire logic [1:0] i_order,
  input  wire logic [1:0] i_single_channel,
  output logic      [1:0] o_channel,
  output logic            o_at_last
);
  import isc_pkg::*;

  logic [1:0] pos;

  // position in the sequence; >= guards against an order shrunk mid-scan
  always_ff @(posedge i_mclk) begin
    if (i_reset || i_restart) begin
      pos <= 2'h0;
    end else if (i_advance) begin
      pos <= o_at_last ? 2'h0 : pos + 2'h1;
    end
  end

  // single mode converts one channel over and over
  assign o_channel = i_scan_on ? pos : i_single_channel;
  assign o_at_last = !i_scan_on || (pos >= isc_last_channel(i_order));
endmodule
`default_nettype wire

// [design/isc_device.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - single mode converts on selected channel
// - host selects channels 2, 3 in single mode only four-channel
// - sleep bit resets to one, controls sleep
// - override drives conversion with programmed level
// - style zero activates at maximum current
// - style one activates with channel drive
// - correction off freezes calibrated drive level
// - reference source internal or external pin
// - mask bit stops interrupt on status update
// - boost bit drives channel zero harder
// - host writes boost as zero while scanning
// - host writes reserved low bits as 000001
// - host keeps reserved bit eight zero
// - scan bit picks single or sequenced mode
// - scan converts each sequence channel, restarts
module isc_device
  import isc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  isc_link_if.device       link,
  input  wire logic        i_external_reference_in,
  input  wire logic [19:0] i_conversion_drive_level,
  input  wire logic [19:0] i_per_channel_drive,
  input  wire logic [4:0]  i_amp_estimate,
  output logic      [4:0]  o_sensor_drive,
  output logic             o_boost_ch0,
  output logic      [1:0]  o_active_channel,
  output logic             o_sleep,
  output logic             o_activating,
  output logic             o_converting,
  output logic             o_ref_external,
  output logic      [2:0]  o_deglitch,
  output logic             o_amp_correction_on,
  output logic             o_status_update,
  output logic      [19:0] o_calibrated_drive_level
);
  import isc_pkg::*;

  logic [15:0] control_word;
  logic [15:0] scan_config;
  logic        ack;
  logic [15:0] rdata;
  logic        int_pending;
  isc_state_t  state;
  isc_state_t  next_state;
  logic [7:0]  tick_count;
  logic [7:0]  next_tick_count;
  logic [19:0] cal_level;
  logic        ref_s1;
  logic        ref_s2;
  logic        ref_s3;
  logic [7:0]  osc_count;
  logic        osc_tick;
  logic        ref_tick;
  logic        phase_done;
  logic [1:0]  channel;
  logic        at_last;
  logic        advance;
  logic [1:0]  next_channel;
  logic        status_update;
  logic        taken;
  logic        sleep_req;

  assign taken     = link.req && !ack;
  assign sleep_req = control_word[CW_SLEEP];

  // register writes land on the cycle the request is taken
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      control_word <= CONTROL_WORD_RESET;
      scan_config  <= SCAN_CONFIG_RESET;
    end else if (taken && link.we) begin
      if (link.addr == ADDR_CONTROL_WORD) begin
        control_word <= link.wdata;
      end
      if (link.addr == ADDR_SCAN_CONFIG) begin
        scan_config <= link.wdata;
      end
    end
  end

  // one-cycle answer; unmapped reads return zero
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack   <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      ack <= taken;
      if (taken && !link.we) begin
        case (link.addr)
          ADDR_CONTROL_WORD: rdata <= control_word;
          ADDR_SCAN_CONFIG:  rdata <= scan_config;
          default:           rdata <= 16'h0000;
        endcase
      end
    end
  end

  // external reference pin: two flops, then an edge detector on the second
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else begin
      ref_s1 <= i_external_reference_in;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  // internal oscillator stand-in, divided from the system clock
  always_ff @(posedge i_mclk) begin
    if (i_reset || osc_tick) begin
      osc_count <= 8'h00;
    end else begin
      osc_count <= osc_count + 8'h01;
    end
  end

  assign osc_tick = (osc_count == 8'(INT_OSC_CYCLES - 1));
  // a stopped external reference stalls conversion, it does not fall back
  assign ref_tick = control_word[CW_REF_SRC] ? (ref_s2 && !ref_s3) : osc_tick;

  isc_scan_seq u_isc_scan_seq (
    .i_mclk           (i_mclk),
    .i_reset          (i_reset),
    .i_restart        (state == ST_SLEEP),
    .i_advance        (advance),
    .i_scan_on        (scan_config[SC_SCAN_ON]),
    .i_order          (scan_config[SC_ORDER_HI:SC_ORDER_LO]),
    .i_single_channel (control_word[CW_CHAN_HI:CW_CHAN_LO]),
    .o_channel        (channel),
    .o_at_last        (at_last)
  );

  assign phase_done = ref_tick &&
                      (tick_count == ((state == ST_ACTIVATE) ? ACT_TICKS : CONV_TICKS) - 8'h01);
  assign advance       = (state == ST_CONVERT) && phase_done;
  // in scan mode a status update means every channel of the sequence is done
  assign status_update = advance && at_last;
  // channel of the coming phase, so a new activation never shows the old channel's level
  assign next_channel  = (advance && scan_config[SC_SCAN_ON]) ?
                         (at_last ? 2'h0 : channel + 2'h1) : channel;

  // sleep -> activate -> convert, repeated per channel
  always_comb begin
    next_state      = state;
    next_tick_count = tick_count;
    case (state)
      ST_SLEEP: begin
        next_tick_count = 8'h00;
        if (!sleep_req) begin
          next_state = ST_ACTIVATE;
        end
      end
      ST_ACTIVATE: begin
        if (ref_tick) begin
          next_tick_count = tick_count + 8'h01;
        end
        if (phase_done) begin
          next_state      = ST_CONVERT;
          next_tick_count = 8'h00;
        end
      end
      ST_CONVERT: begin
        if (ref_tick) begin
          next_tick_count = tick_count + 8'h01;
        end
        if (phase_done) begin
          next_state      = ST_ACTIVATE;
          next_tick_count = 8'h00;
        end
      end
      default: begin
        next_state      = ST_SLEEP;
        next_tick_count = 8'h00;
      end
    endcase
    if (sleep_req) begin
      next_state      = ST_SLEEP;
      next_tick_count = 8'h00;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state      <= ST_SLEEP;
      tick_count <= 8'h00;
    end else begin
      state      <= next_state;
      tick_count <= next_tick_count;
    end
  end

  // calibrated level follows the amplitude estimate after each activation
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cal_level <= 20'h00000;
    end else if (state == ST_ACTIVATE && phase_done && !control_word[CW_AMP_OFF]) begin
      cal_level[channel*5 +: 5] <= i_amp_estimate;
    end
  end

  // sensor drive current per phase, registered so it never glitches
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_sensor_drive <= 5'h00;
      o_boost_ch0    <= 1'b0;
    end else begin
      case (next_state)
        ST_ACTIVATE: o_sensor_drive <= control_word[CW_ACT_STYLE] ?
                                       isc_pick5(i_per_channel_drive, next_channel) :
                                       FULL_DRIVE;
        ST_CONVERT:  o_sensor_drive <= control_word[CW_OVERRIDE] ?
                                       isc_pick5(i_conversion_drive_level, channel) :
                                       isc_pick5(cal_level, channel);
        default:     o_sensor_drive <= 5'h00;
      endcase
      // boost only on channel 0; scanning with boost is left to the host
      o_boost_ch0 <= control_word[CW_BOOST] && (next_state != ST_SLEEP) &&
                     (next_channel == 2'h0);
    end
  end

  // interrupt: set on status update unless masked, cleared by any read; set wins
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      int_pending <= 1'b0;
    end else if (status_update && !control_word[CW_INT_MASK]) begin
      int_pending <= 1'b1;
    end else if (taken && !link.we) begin
      int_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_status_update <= 1'b0;
    end else begin
      o_status_update <= status_update;
    end
  end

  assign link.ack                 = ack;
  assign link.rdata               = rdata;
  assign link.int_n               = !int_pending;
  assign o_active_channel         = channel;
  assign o_sleep                  = (state == ST_SLEEP);
  assign o_activating             = (state == ST_ACTIVATE);
  assign o_converting             = (state == ST_CONVERT);
  assign o_ref_external           = control_word[CW_REF_SRC];
  assign o_deglitch               = scan_config[SC_DEGLITCH_HI:0];
  assign o_amp_correction_on      = !control_word[CW_AMP_OFF];
  assign o_calibrated_drive_level = cal_level;
endmodule
`default_nettype wire

// [design/isc_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host controller: avalon commands become link register transfers
module isc_host
  import isc_pkg::*;
#(
  parameter bit FOUR_CHANNEL = 1'b1
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  isc_link_if.host         link,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest
);
  import isc_pkg::*;

  logic [7:0]  cmd_addr;
  logic [15:0] cmd_data;
  logic [15:0] rd_data;
  logic        busy;
  logic        is_read;
  logic        scan_on;
  logic        av_ack;
  logic        int_s1;
  logic        int_s2;
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        av_wr;
  logic        av_rd;
  logic [15:0] ctrl_clean;

  // avalon answers one cycle after the request appears
  assign av_wr             = i_avs_write && !av_ack;
  assign av_rd             = i_avs_read && !av_ack;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !av_ack;

  // the device is trusted to be told only legal control words
  always_comb begin
    ctrl_clean                      = cmd_data;
    ctrl_clean[CW_RSVD_HI:0]        = CW_RSVD_LOW_VALUE;
    ctrl_clean[CW_RSVD8]            = 1'b0;
    if (!FOUR_CHANNEL) begin
      ctrl_clean[CW_CHAN_HI]        = 1'b0;
    end
    if (scan_on) begin
      ctrl_clean[CW_BOOST]          = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      av_ack         <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end else begin
      av_ack <= av_wr || av_rd;
      if (av_rd) begin
        case (i_avs_address)
          HOST_CMD_ADDR: o_avs_readdata <= {24'h000000, cmd_addr};
          HOST_CMD_DATA: o_avs_readdata <= {16'h0000, cmd_data};
          HOST_STATUS:   o_avs_readdata <= {rd_data, 14'h0000, !int_s2, busy};
          default:       o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // command registers, byte lanes honoured
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cmd_addr <= 8'h00;
      cmd_data <= 16'h0000;
    end else if (av_wr) begin
      if (i_avs_address == HOST_CMD_ADDR && i_avs_byteenable[0]) begin
        cmd_addr <= i_avs_writedata[7:0];
      end
      if (i_avs_address == HOST_CMD_DATA) begin
        if (i_avs_byteenable[0]) begin
          cmd_data[7:0] <= i_avs_writedata[7:0];
        end
        if (i_avs_byteenable[1]) begin
          cmd_data[15:8] <= i_avs_writedata[15:8];
        end
      end
    end
  end

  // link transfer: start on a go bit, ignored while busy
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      busy    <= 1'b0;
      is_read <= 1'b0;
      req     <= 1'b0;
      we      <= 1'b0;
      addr    <= 8'h00;
      wdata   <= 16'h0000;
      rd_data <= 16'h0000;
      scan_on <= 1'b0;
    end else if (busy) begin
      if (link.ack) begin
        req  <= 1'b0;
        busy <= 1'b0;
        if (is_read) begin
          rd_data <= link.rdata;
        end
      end
    end else if (av_wr && i_avs_address == HOST_CTRL && i_avs_byteenable[0] &&
                 (i_avs_writedata[HOST_GO_WRITE] || i_avs_writedata[HOST_GO_READ])) begin
      busy    <= 1'b1;
      req     <= 1'b1;
      addr    <= cmd_addr;
      is_read <= !i_avs_writedata[HOST_GO_WRITE];
      we      <= i_avs_writedata[HOST_GO_WRITE];
      wdata   <= (cmd_addr == ADDR_CONTROL_WORD) ? ctrl_clean : cmd_data;
      if (i_avs_writedata[HOST_GO_WRITE] && cmd_addr == ADDR_SCAN_CONFIG) begin
        scan_on <= cmd_data[SC_SCAN_ON];
      end
    end
  end

  // interrupt pin treated as a pin: two flops before use
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      int_s1 <= 1'b1;
      int_s2 <= 1'b1;
    end else begin
      int_s1 <= link.int_n;
      int_s2 <= int_s1;
    end
  end

  assign link.req   = req;
  assign link.we    = we;
  assign link.addr  = addr;
  assign link.wdata = wdata;
endmodule
`default_nettype wire

// [bench/isc_link_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// link checker; shadows the control word from the writes the device takes
module isc_link_sva
  import isc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        ack,
  input  wire logic        int_n
);
  logic [15:0] cw_q;
  logic        scan_q;
  logic        mask_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // a write lands on the edge that takes it, so the shadow moves on that same edge
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cw_q <= CONTROL_WORD_RESET;
      scan_q <= SCAN_CONFIG_RESET[SC_SCAN_ON];
    end else if (req && we && !ack) begin
      if (addr == ADDR_CONTROL_WORD) cw_q <= wdata;
      if (addr == ADDR_SCAN_CONFIG) scan_q <= wdata[SC_SCAN_ON];
    end
  end
  assign mask_q = cw_q[CW_INT_MASK];

  property p_ack_pulse;
    req && !ack |=> ack ##1 !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("link ack late or long");
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("link ack without request");
  property p_cw_read;
    ack && !we && addr == ADDR_CONTROL_WORD |-> rdata == cw_q;
  endproperty
  a_cw_read: assert property (p_cw_read) else $error("control word readback wrong");
  property p_unmapped;
    ack && !we && addr != ADDR_CONTROL_WORD && addr != ADDR_SCAN_CONFIG |-> rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_int_reset;
    $fell(i_reset) |-> int_n;
  endproperty
  a_int_reset: assert property (p_int_reset) else $error("interrupt active after reset");
  // allow two cycles for the mask to reach the pending flag
  property p_int_masked;
    int_n && mask_q && $past(mask_q, 2) |=> int_n;
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("masked interrupt raised");
  property p_rsvd;
    req && we && addr == ADDR_CONTROL_WORD
      |-> wdata[CW_RSVD_HI:0] == CW_RSVD_LOW_VALUE && !wdata[CW_RSVD8];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits written wrong");
  property p_no_boost;
    req && we && addr == ADDR_CONTROL_WORD && scan_q |-> !wdata[CW_BOOST];
  endproperty
  a_no_boost: assert property (p_no_boost) else $error("boost written while scanning");
endmodule
`default_nettype wire

// [bench/isc_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// compare, count, and report a miss at once
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end \
end
module isc_bench;
  import isc_pkg::*;
  localparam logic [19:0] CONV_LVL = {5'h0C, 5'h09, 5'h06, 5'h03};
  localparam logic [19:0] CHAN_LVL = {5'h14, 5'h12, 5'h10, 5'h0E};
  logic        mclk;
  logic        reset;
  logic [3:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        ext_ref = 1'b0;
  logic [4:0]  amp_est;
  logic [4:0]  drive;
  logic        boost;
  logic [1:0]  chan;
  logic        sleep;
  logic        act;
  logic        conv;
  logic        ref_ext;
  logic        amp_on;
  logic [19:0] cal;
  logic [2:0]  deglitch;
  logic        stat_upd;
  int          n_errors;
  int          cmp_count;
  isc_link_if link ();

  isc_device u_isc_device (
    .i_mclk(mclk), .i_reset(reset), .link(link), .i_external_reference_in(ext_ref),
    .i_conversion_drive_level(CONV_LVL), .i_per_channel_drive(CHAN_LVL),
    .i_amp_estimate(amp_est), .o_sensor_drive(drive), .o_boost_ch0(boost),
    .o_active_channel(chan), .o_sleep(sleep), .o_activating(act), .o_converting(conv),
    .o_ref_external(ref_ext), .o_deglitch(deglitch), .o_amp_correction_on(amp_on),
    .o_status_update(stat_upd), .o_calibrated_drive_level(cal));
  isc_host u_isc_host (
    .i_mclk(mclk), .i_reset(reset), .link(link), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait));
  isc_link_sva u_isc_link_sva (
    .i_mclk(mclk), .i_reset(reset), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .int_n(link.int_n));

  // clock; the reference pin toggles every cycle so external ticks come fast
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) ext_ref <= ~ext_ref;

  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic av_xfer(input logic is_wr, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge mclk);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= is_wr;
    av_rd <= !is_wr;
    // no answer time is assumed; only the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  // one link transfer through the host: address, data, go, then poll busy
  task automatic lnk(input logic is_wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    logic [31:0] q;
    av_xfer(1'b1, HOST_CMD_ADDR, {24'h000000, a}, q);
    av_xfer(1'b1, HOST_CMD_DATA, {16'h0000, d}, q);
    av_xfer(1'b1, HOST_CTRL, 32'h1 << (is_wr ? HOST_GO_WRITE : HOST_GO_READ), q);
    do begin
      av_xfer(1'b0, HOST_STATUS, 32'h00000000, q);
    end while (q[0] !== 1'b0);
    r = q[31:16];
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    lnk(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] r;
    lnk(1'b0, a, 16'h0000, r);
    `CHK(r, e);
  endtask

  // 0 activation, 1 conversion, 2 interrupt pending
  function automatic logic pick(input int sel);
    return (sel == 0) ? act : ((sel == 1) ? conv : !link.int_n);
  endfunction
  // bounded wait for a fresh rise, so a stalled sequencer cannot hang the run
  task automatic wait_rise(input int sel);
    int n;
    n = 0;
    while (pick(sel) === 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    while (pick(sel) !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 1000) n_errors++;
  endtask

  task automatic t_reset_vals();
    rd_chk(ADDR_CONTROL_WORD, CONTROL_WORD_RESET);
    rd_chk(ADDR_SCAN_CONFIG, SCAN_CONFIG_RESET);
    `CHK(sleep, 1'b1);
    `CHK(deglitch, SCAN_CONFIG_RESET[SC_DEGLITCH_HI:0]);
  endtask

  // all ones through the host, unmapped places, then a reset in mid-run
  task automatic t_fields();
    logic [31:0] q;
    wr_reg(ADDR_CONTROL_WORD, 16'hFFFF);
    rd_chk(ADDR_CONTROL_WORD, 16'hFEC1);
    `CHK(amp_on, 1'b0);
    wr_reg(ADDR_SCAN_CONFIG, 16'h820F);
    wr_reg(8'h05, 16'hFFFF);
    wr_reg(ADDR_CONTROL_WORD, 16'hFFFF);
    rd_chk(ADDR_CONTROL_WORD, 16'hFE81);
    rd_chk(8'h05, 16'h0000);
    av_xfer(1'b0, 4'h2, 32'h00000000, q);
    `CHK(q, 32'h00000000);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_reset_vals();
  endtask

  // each channel alone, varying style, override, correction and reference
  task automatic t_channels();
    logic [15:0] w;
    logic [4:0]  lvl;
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_CONTROL_WORD, CONTROL_WORD_RESET);
      `CHK(sleep, 1'b1);
      lvl = 5'h10 + 5'(i);
      amp_est <= lvl;
      w = {i[1:0], 1'b0, i != 1, i < 2, i == 3, i == 2, 2'b00, i == 0, CW_RSVD_LOW_VALUE};
      wr_reg(ADDR_CONTROL_WORD, w);
      wait_rise(0);
      repeat (2) @(posedge mclk);
      `CHK(chan, i[1:0]);
      `CHK(drive, (i < 2) ? CHAN_LVL[i*5 +: 5] : FULL_DRIVE);
      `CHK(boost, i == 0);
      `CHK(ref_ext, i == 2);
      wait_rise(1);
      repeat (2) @(posedge mclk);
      `CHK(drive, (i != 1) ? CONV_LVL[i*5 +: 5] : lvl);
      `CHK(cal[i*5 +: 5], (i == 3) ? 5'h00 : lvl);
      if (i == 0) begin
        rd_chk(ADDR_CONTROL_WORD, w);
        wait_rise(2);
        `CHK(link.int_n, 1'b0);
        `CHK(stat_upd, 1'b1);
        av_xfer(1'b0, HOST_STATUS, 32'h00000000, q);
        `CHK(q[1], 1'b1);
        rd_chk(ADDR_SCAN_CONFIG, SCAN_CONFIG_RESET);
        `CHK(link.int_n, 1'b1);
      end
    end
  endtask

  // every scan order, interrupt masked; the read clears anything left pending
  task automatic t_scan();
    int last;
    for (int o = 0; o < 4; o++) begin
      last = (o == 2) ? 3 : ((o == 1) ? 2 : 1);
      wr_reg(ADDR_CONTROL_WORD, 16'h2881);
      rd_chk(ADDR_CONTROL_WORD, 16'h2881);
      wr_reg(ADDR_SCAN_CONFIG, {1'b1, o[1:0], SCAN_CONFIG_RESET[12:0]});
      wr_reg(ADDR_CONTROL_WORD, 16'h0081);
      `CHK(act, 1'b1);
      `CHK(chan, 2'h0);
      for (int k = 1; k <= last + 1; k++) begin
        wait_rise(0);
        `CHK(chan, (k > last) ? 2'h0 : k[1:0]);
      end
      `CHK(link.int_n, 1'b1);
    end
  endtask

  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    av_addr = 4'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = 32'h00000000;
    amp_est = 5'h00;
    n_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_reset_vals();
    t_fields();
    t_channels();
    t_scan();
    results();
  end

  // the tests need well under 10000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
